/* File: hw/evt_timer.sv */
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
module evt_timer
	import evt_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic EXTERNAL_CLOCK_PIN,
	input wire logic EXTERNAL_CLEAR_PIN,
	input wire logic START_TRIGGER_PIN,
	output logic WAVEFORM_OUT_PIN,
	output logic IRQ_MATCH_A,
	output logic IRQ_MATCH_B,
	output logic IRQ_OVERFLOW
);
	import evt_pkg::*;

	// ==========================================================
	// state
	logic [7:0] cnt_q, cnt_d;
	logic [7:0] cmpa_q, cmpb_q;
	logic [7:0] ctrl0_q, ctrl1_q;
	logic [3:0] os_q;
	logic [2:0] flags_q, flags_d;
	logic [2:0] arm_q, arm_d;
	logic ma_seen_q, mb_seen_q;
	logic [EVT_PRESC_W-1:0] presc_q;
	logic out_q, out_d;
	logic [2:0] irq_q;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	evt_run_e run_q, run_d;

	// ==========================================================
	// pin edges
	logic ck_rise, ck_fall, clr_rise, trg_rise, trg_fall;

	evt_pin_edge u_ck (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.pin(EXTERNAL_CLOCK_PIN),
		.rise(ck_rise),
		.fall(ck_fall)
	);

	evt_pin_edge u_clr (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.pin(EXTERNAL_CLEAR_PIN),
		.rise(clr_rise),
		.fall()
	);

	evt_pin_edge u_trg (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.pin(START_TRIGGER_PIN),
		.rise(trg_rise),
		.fall(trg_fall)
	);

	// ==========================================================
	// apb decode; one wait state so read data comes from a flop
	wire access = PSEL & PENABLE;
	wire done = access & pready_q;
	wire hit_cnt = PADDR == EVT_OFF_COUNT;
	wire hit_cmpa = PADDR == EVT_OFF_CMPA;
	wire hit_cmpb = PADDR == EVT_OFF_CMPB;
	wire hit_c0 = PADDR == EVT_OFF_CTRL0;
	wire hit_st = PADDR == EVT_OFF_STAT;
	wire hit_c1 = PADDR == EVT_OFF_CTRL1;
	wire hit_any = hit_cnt | hit_cmpa | hit_cmpb | hit_c0 | hit_st | hit_c1;
	wire wr_done = done & PWRITE;
	wire wr_cnt = wr_done & hit_cnt;
	wire wr_st = wr_done & hit_st;
	wire rd_st = done & ~PWRITE & hit_st;
	wire [7:0] wdat = PWDATA[7:0];
	wire [7:0] stat_rd = {flags_q, 1'b0, os_q} | EVT_ST_ONES;
	wire [7:0] rd_mux = ({8{hit_cnt}} & cnt_q) | ({8{hit_cmpa}} & cmpa_q)
		| ({8{hit_cmpb}} & cmpb_q) | ({8{hit_c0}} & ctrl0_q)
		| ({8{hit_st}} & stat_rd) | ({8{hit_c1}} & (ctrl1_q | EVT_C1_ONES));

	// ==========================================================
	// control fields
	wire [2:0] cks = ctrl0_q[EVT_C0_CKS_HI:EVT_C0_CKS_LO];
	wire [1:0] clr_sel = ctrl0_q[EVT_C0_CLR_HI:EVT_C0_CLR_LO];
	wire [2:0] ie = {ctrl0_q[EVT_C0_IE_B], ctrl0_q[EVT_C0_IE_A], ctrl0_q[EVT_C0_IE_OVF]};
	wire [1:0] trg_sel = ctrl1_q[EVT_C1_EDGE_HI:EVT_C1_EDGE_LO];
	wire trigger_start_enable = ctrl1_q[EVT_C1_TRIGGER_START_ENABLE];
	wire extra = ctrl1_q[EVT_C1_EXTRA];
	wire [1:0] os_a = os_q[EVT_ST_OS_A_HI:EVT_ST_OS_A_LO];
	wire [1:0] os_b = os_q[EVT_ST_OS_B_HI:EVT_ST_OS_B_LO];

	// ==========================================================
	// count source
	wire [EVT_PRESC_W-1:0] tap = evt_tap_mask(cks[1:0], extra);
	wire int_tick = (presc_q & tap) == tap;
	wire ext_tick = evt_edge_hit(cks[1:0], ck_rise, ck_fall);
	wire stopped = (cks == EVT_CKS_STOP0) | (cks == EVT_CKS_STOP1);
	wire tick = ~stopped & (cks[2] ? ext_tick : int_tick);
	wire trg_hit = trigger_start_enable & evt_edge_hit(trg_sel, trg_rise, trg_fall);
	wire running = ~trigger_start_enable | (run_q == EVT_COUNTING);
	wire count_en = tick & running;

	// ==========================================================
	// compare; a write access to a constant masks its compare
	wire sup_a = access & PWRITE & hit_cmpa;
	wire sup_b = access & PWRITE & hit_cmpb;
	wire ma_now = (cnt_q == cmpa_q) & ~sup_a;
	wire mb_now = (cnt_q == cmpb_q) & ~sup_b;
	// one event per entry into equality, not one per cycle of it
	wire ma_evt = ma_now & ~ma_seen_q;
	wire mb_evt = mb_now & ~mb_seen_q;

	// ==========================================================
	// counter next value
	wire clr_evt = ((clr_sel == EVT_CLR_MATCH_A) & ma_evt)
		| ((clr_sel == EVT_CLR_MATCH_B) & mb_evt)
		| ((clr_sel == EVT_CLR_PIN) & clr_rise);
	// a software write to the counter wins over clear and count
	wire ovf_evt = count_en & (cnt_q == 8'hff) & ~wr_cnt & ~clr_evt;

	always_comb begin
		if (wr_cnt) begin
			cnt_d = wdat;
		end else if (clr_evt) begin
			cnt_d = 8'h00;
		end else if (count_en) begin
			cnt_d = cnt_q + 8'h01;
		end else begin
			cnt_d = cnt_q;
		end
	end

	// ==========================================================
	// start and stop; with trigger enable off the timer free-runs
	always_comb begin
		run_d = run_q;
		unique case (run_q)
			EVT_HALTED: begin
				if (trg_hit) begin
					run_d = EVT_COUNTING;
				end
			end
			EVT_COUNTING: begin
				if (clr_evt & ~trg_hit) begin
					run_d = EVT_HALTED;
				end
			end
		endcase
		if (~trigger_start_enable) begin
			run_d = EVT_HALTED;
		end
	end

	// ==========================================================
	// flags: set wins over clear, clear needs a prior read of one
	wire [2:0] flag_set = {mb_evt, ma_evt, ovf_evt};
	wire [2:0] wr_zero = ~{wdat[EVT_ST_FLAG_B], wdat[EVT_ST_FLAG_A], wdat[EVT_ST_FLAG_OVF]};
	wire [2:0] flag_clr = arm_q & {3{wr_st}} & wr_zero;

	assign flags_d = flag_set | (flags_q & ~flag_clr);
	assign arm_d = (arm_q | ({3{rd_st}} & flags_q)) & flags_d;

	// ==========================================================
	// waveform output; b acts after a when both match together
	wire out_mid = ma_evt ? evt_out_next(os_a, out_q) : out_q;
	assign out_d = mb_evt ? evt_out_next(os_b, out_mid) : out_mid;

	// ==========================================================
	// registers
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			cnt_q <= EVT_RST_COUNT;
			run_q <= EVT_HALTED;
			presc_q <= '0;
			ma_seen_q <= 1'b0;
			mb_seen_q <= 1'b0;
			flags_q <= 3'h0;
			arm_q <= 3'h0;
			out_q <= 1'b0;
			irq_q <= 3'h0;
		end else begin
			cnt_q <= cnt_d;
			run_q <= run_d;
			presc_q <= presc_q + 1'b1;
			ma_seen_q <= ma_now;
			mb_seen_q <= mb_now;
			flags_q <= flags_d;
			arm_q <= arm_d;
			out_q <= out_d;
			irq_q <= flags_q & ie;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			cmpa_q <= EVT_RST_CMP;
			cmpb_q <= EVT_RST_CMP;
			ctrl0_q <= EVT_RST_CTRL;
			ctrl1_q <= EVT_RST_CTRL;
			os_q <= EVT_RST_OS;
		end else if (wr_done) begin
			if (hit_cmpa) cmpa_q <= wdat;
			if (hit_cmpb) cmpb_q <= wdat;
			if (hit_c0) ctrl0_q <= wdat;
			if (hit_c1) ctrl1_q <= wdat & EVT_C1_MASK;
			if (hit_st) os_q <= wdat[3:0];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= EVT_RST_RDATA;
		end else begin
			pready_q <= access & ~pready_q;
			pslverr_q <= access & ~pready_q & ~hit_any;
			if (access & ~pready_q) prdata_q <= PWRITE ? EVT_RST_RDATA : {24'h00_0000, rd_mux};
		end
	end

	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign WAVEFORM_OUT_PIN = out_q;
	assign IRQ_MATCH_B = irq_q[2];
	assign IRQ_MATCH_A = irq_q[1];
	assign IRQ_OVERFLOW = irq_q[0];

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	a_cnt_step: assert property (count_en && !clr_evt && !wr_cnt |=>
		cnt_q == 8'($past(cnt_q) + 8'h01)) else $error("counter did not step by one");
	a_ovf_wrap: assert property (ovf_evt |=> flags_q[0] && cnt_q == 8'h00)
		else $error("overflow did not wrap and flag");
	a_cnt_write: assert property (wr_cnt |=> cnt_q == $past(wdat))
		else $error("counter write lost");
	a_match_flag: assert property ((cnt_q == cmpa_q) && !sup_a && !ma_seen_q |=> flags_q[1])
		else $error("match a did not set its flag");
	a_cmp_masked: assert property (access && PWRITE && hit_cmpb |-> !mb_evt)
		else $error("compare b ran during its write");
	a_irq_gate: assert property (flags_q[1] && ctrl0_q[EVT_C0_IE_A] |=> IRQ_MATCH_A)
		else $error("match a interrupt missing");
	a_irq_ovf_off: assert property (!ctrl0_q[EVT_C0_IE_OVF] |=> !IRQ_OVERFLOW)
		else $error("overflow interrupt not gated");
	a_clear_on_b: assert property (clr_sel == EVT_CLR_MATCH_B && mb_evt && !wr_cnt
		|=> cnt_q == 8'h00) else $error("match b clear failed");
	a_stop_codes: assert property (stopped |-> !count_en)
		else $error("counting while clock stopped");
	a_flag_hold: assert property (flags_q[2] && !(arm_q[2] && wr_st) |=> flags_q[2])
		else $error("flag b cleared without read");
	a_out_toggle: assert property (ma_evt && !mb_evt && os_a == EVT_OUT_TOGGLE
		|=> WAVEFORM_OUT_PIN != $past(out_q)) else $error("output did not toggle");
	a_trg_halt: assert property (trigger_start_enable && clr_evt && !trg_hit |=> run_q == EVT_HALTED
		&& (!count_en || !trigger_start_enable)) else $error("match clear did not halt");

	// ==========================================================
	// checks: counting and clearing
	a_cnt_hold: assert property (!count_en && !clr_evt && !wr_cnt
		|=> $stable(cnt_q)) else $error("counter moved without cause");
	a_int_spacing: assert property (int_tick |=> !int_tick)
		else $error("internal ticks too close");
	a_ext_both: assert property (cks[2] && &cks[1:0]
		|-> tick == (ck_rise | ck_fall)) else $error("both-edge count source wrong");
	a_clear_on_a: assert property (clr_sel == EVT_CLR_MATCH_A && ma_evt && !wr_cnt
		|=> cnt_q == 8'h00) else $error("match a clear failed");
	a_clear_on_pin: assert property (clr_sel == EVT_CLR_PIN && clr_rise && !wr_cnt
		|=> cnt_q == 8'h00) else $error("pin clear failed");
	a_no_clear: assert property (clr_sel == EVT_CLR_NONE |-> !clr_evt)
		else $error("clear while clearing disabled");

	// ==========================================================
	// checks: flags and interrupts
	a_ovf_only: assert property (!ovf_evt && !flags_q[0] |=> !flags_q[0])
		else $error("overflow flag set without overflow");
	a_match_b_flag: assert property (mb_evt |=> flags_q[2])
		else $error("match b did not set its flag");
	a_cmp_a_masked: assert property (sup_a |-> !ma_evt)
		else $error("compare a ran during its write");
	a_irq_b_gate: assert property (flags_q[2] && ctrl0_q[EVT_C0_IE_B]
		|=> IRQ_MATCH_B) else $error("match b interrupt missing");
	a_irq_a_off: assert property (!ctrl0_q[EVT_C0_IE_A] |=> !IRQ_MATCH_A)
		else $error("match a interrupt not gated");
	a_irq_ovf_gate: assert property (flags_q[0] && ctrl0_q[EVT_C0_IE_OVF]
		|=> IRQ_OVERFLOW) else $error("overflow interrupt missing");
	a_flag_a_hold: assert property (flags_q[1] && !(arm_q[1] && wr_st)
		|=> flags_q[1]) else $error("flag a cleared without read");
	a_arm_needs_read: assert property (!arm_q[0] && !rd_st |=> !arm_q[0])
		else $error("overflow flag armed without read");

	// ==========================================================
	// checks: start, stop and output
	a_trg_wait: assert property (trigger_start_enable && run_q == EVT_HALTED |-> !count_en)
		else $error("counting before trigger");
	a_trg_start: assert property (trg_hit |=> run_q == EVT_COUNTING)
		else $error("trigger edge did not start");
	a_free_run: assert property (!trigger_start_enable |-> count_en == tick)
		else $error("free run blocked");
	a_out_low_b: assert property (mb_evt && os_b == EVT_OUT_LOW
		|=> !WAVEFORM_OUT_PIN) else $error("output not driven low");
	a_out_high_b: assert property (mb_evt && os_b == EVT_OUT_HIGH
		|=> WAVEFORM_OUT_PIN) else $error("output not driven high");
	a_out_keep: assert property (!ma_evt && !mb_evt
		|=> $stable(WAVEFORM_OUT_PIN)) else $error("output moved without a match");
endmodule

/* File: hw/evt_pkg.sv */
package evt_pkg;

	// ==========================================================
	// register map (byte addresses on the apb bus)
	localparam logic [7:0] EVT_OFF_COUNT = 8'h00;
	localparam logic [7:0] EVT_OFF_CMPA = 8'h04;
	localparam logic [7:0] EVT_OFF_CMPB = 8'h08;
	localparam logic [7:0] EVT_OFF_CTRL0 = 8'h0c;
	localparam logic [7:0] EVT_OFF_STAT = 8'h10;
	localparam logic [7:0] EVT_OFF_CTRL1 = 8'h14;

	// ==========================================================
	// primary_timer_control fields
	localparam int EVT_C0_IE_B = 7;
	localparam int EVT_C0_IE_A = 6;
	localparam int EVT_C0_IE_OVF = 5;
	localparam int EVT_C0_CLR_HI = 4;
	localparam int EVT_C0_CLR_LO = 3;
	localparam int EVT_C0_CKS_HI = 2;
	localparam int EVT_C0_CKS_LO = 0;

	// ==========================================================
	// timer_status_output_control fields
	localparam int EVT_ST_FLAG_B = 7;
	localparam int EVT_ST_FLAG_A = 6;
	localparam int EVT_ST_FLAG_OVF = 5;
	localparam int EVT_ST_OS_B_HI = 3;
	localparam int EVT_ST_OS_B_LO = 2;
	localparam int EVT_ST_OS_A_HI = 1;
	localparam int EVT_ST_OS_A_LO = 0;
	localparam logic [7:0] EVT_ST_ONES = 8'h10;

	// ==========================================================
	// secondary_timer_control fields
	localparam int EVT_C1_EDGE_HI = 4;
	localparam int EVT_C1_EDGE_LO = 3;
	localparam int EVT_C1_TRIGGER_START_ENABLE = 2;
	localparam int EVT_C1_EXTRA = 0;
	localparam logic [7:0] EVT_C1_ONES = 8'he0;
	localparam logic [7:0] EVT_C1_MASK = 8'h1d;

	// ==========================================================
	// reset values
	localparam logic [7:0] EVT_RST_COUNT = 8'h00;
	localparam logic [7:0] EVT_RST_CMP = 8'hff;
	localparam logic [7:0] EVT_RST_CTRL = 8'h00;
	localparam logic [3:0] EVT_RST_OS = 4'h0;
	localparam logic [31:0] EVT_RST_RDATA = 32'h0000_0000;

	// ==========================================================
	// field codes
	localparam logic [1:0] EVT_CLR_NONE = 2'h0;
	localparam logic [1:0] EVT_CLR_MATCH_A = 2'h1;
	localparam logic [1:0] EVT_CLR_MATCH_B = 2'h2;
	localparam logic [1:0] EVT_CLR_PIN = 2'h3;
	localparam logic [1:0] EVT_OUT_KEEP = 2'h0;
	localparam logic [1:0] EVT_OUT_LOW = 2'h1;
	localparam logic [1:0] EVT_OUT_HIGH = 2'h2;
	localparam logic [1:0] EVT_OUT_TOGGLE = 2'h3;
	localparam logic [1:0] EVT_EDGE_OFF = 2'h0;
	localparam logic [1:0] EVT_EDGE_RISE = 2'h1;
	localparam logic [1:0] EVT_EDGE_FALL = 2'h2;
	localparam logic [1:0] EVT_EDGE_BOTH = 2'h3;
	localparam logic [2:0] EVT_CKS_STOP0 = 3'h0;
	localparam logic [2:0] EVT_CKS_STOP1 = 3'h4;
	localparam int EVT_PRESC_W = 7;

	typedef enum logic {EVT_HALTED, EVT_COUNTING} evt_run_e;

	// ==========================================================
	// helpers
	function automatic logic evt_edge_hit(input logic [1:0] sel, input logic rise,
		input logic fall);
		evt_edge_hit = (sel[0] & rise) | (sel[1] & fall);
	endfunction

	function automatic logic evt_out_next(input logic [1:0] act, input logic cur);
		logic r;
		r = cur;
		unique case (act)
			EVT_OUT_KEEP: r = cur;
			EVT_OUT_LOW: r = 1'b0;
			EVT_OUT_HIGH: r = 1'b1;
			EVT_OUT_TOGGLE: r = ~cur;
		endcase
		evt_out_next = r;
	endfunction

	// falling edge of phi/2^(k+1) comes when the low k+1 prescaler bits are all ones
	function automatic logic [EVT_PRESC_W-1:0] evt_tap_mask(input logic [1:0] cks,
		input logic extra);
		logic [2:0] k;
		k = 3'({cks, 1'b0} - 3'd1) + 3'(extra);
		evt_tap_mask = EVT_PRESC_W'((8'h02 << k) - 8'h01);
	endfunction

endpackage

/* File: hw/evt_pin_edge.sv */
`timescale 1ns/100ps
module evt_pin_edge (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	output logic rise,
	output logic fall
);
	// ==========================================================
	// two-stage synchroniser, then edge detect on the second stage only
	logic meta_q;
	logic sync_q;
	logic prev_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;
endmodule

/* File: dv/evt_pin_src.sv */
`timescale 1ns/100ps
// ==========================================================
// far-side pin sources: counted clock bursts, trigger and clear levels
module evt_pin_src (
	input wire logic clk,
	input wire logic start,
	input wire logic [7:0] pulses,
	input wire logic [3:0] half,
	input wire logic trig_lvl,
	input wire logic clr_lvl,
	output logic ext_clk,
	output logic trig_pin,
	output logic clr_pin,
	output logic busy
);
	logic [8:0] left;
	logic [3:0] cnt;
	logic [3:0] top;
	// half below 2 is clamped: shorter levels may be lost in the synchroniser
	assign top = (half < 4'h2) ? 4'h1 : half - 4'h1;
	assign busy = (left != 9'h000) | start;
	initial begin
		ext_clk = 1'b0;
		left = 9'h000;
		cnt = 4'h0;
		trig_pin = 1'b0;
		clr_pin = 1'b0;
	end
	// clock stands still outside bursts, each level held two cycles or more
	always @(posedge clk) begin
		trig_pin <= trig_lvl;
		clr_pin <= clr_lvl;
		if (start) begin
			left <= {pulses, 1'b0};
			cnt <= 4'h0;
		end else if (left != 9'h000) begin
			if (cnt >= top) begin
				ext_clk <= ~ext_clk;
				left <= left - 9'h001;
				cnt <= 4'h0;
			end else begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule

/* File: dv/eight_bit_event_timer_test.sv */
`timescale 1ns/100ps
module eight_bit_event_timer_test;
	import evt_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, err;
	logic [7:0] paddr, pulses, va, vb;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, ext_clk, clr_pin, trig_pin, wave, irq_a, irq_b, irq_o;
	logic src_start, trig_lvl, clr_lvl, src_busy;
	logic [3:0] half;
	int bad_count, checks_done, n;
	evt_timer u_evt_timer (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .EXTERNAL_CLOCK_PIN(ext_clk), .EXTERNAL_CLEAR_PIN(clr_pin),
		.START_TRIGGER_PIN(trig_pin), .WAVEFORM_OUT_PIN(wave), .IRQ_MATCH_A(irq_a),
		.IRQ_MATCH_B(irq_b), .IRQ_OVERFLOW(irq_o));
	evt_pin_src u_evt_pin_src (.clk(clk), .start(src_start), .pulses(pulses), .half(half),
		.trig_lvl(trig_lvl), .clr_lvl(clr_lvl), .ext_clk(ext_clk), .trig_pin(trig_pin),
		.clr_pin(clr_pin), .busy(src_busy));
	// ==========================================================
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#240000;
		bad_count++;
		finish_test();
	end
	// ==========================================================
	// expectation helpers
	function automatic int span_of(input int c, input int x);
		return (c == 0 || c == 4) ? 300 : 16 * (4 << ((c - 1) * 2 + x));
	endfunction
	function automatic logic [31:0] near(input logic [31:0] s, input int lo, input int w);
		return 32'(s >= 32'(lo) && s <= 32'(lo + w));
	endfunction
	// ==========================================================
	// checking and apb tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// request held until the edge that samples pready high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check(32'(k < 20), 1);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask
	task automatic wait_wave(input logic lvl);
		n = 0;
		while (wave !== lvl && n < 4000) begin
			@(posedge clk);
			n++;
		end
		check(32'(n < 4000), 1);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, src_start, trig_lvl, clr_lvl} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pulses = 8'h00;
		half = 4'h3;
		bad_count = 0;
		checks_done = 0;
		void'($urandom(92));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rdc(EVT_OFF_COUNT, 32'h0000_0000);
		rdc(EVT_OFF_CMPA, 32'h0000_00ff);
		rdc(EVT_OFF_CMPB, 32'h0000_00ff);
		rdc(EVT_OFF_CTRL0, 32'h0000_0000);
		rdc(EVT_OFF_STAT, {24'h00_0000, EVT_ST_ONES});
		rdc(EVT_OFF_CTRL1, {24'h00_0000, EVT_C1_ONES});
		check(32'(wave), 0);
		apb(1'b1, 8'h18, 32'h0000_00ff);
		check(32'(err), 1);
		rdc(8'h18, 32'h0000_0000);
		check(32'(err), 1);
		for (int i = 0; i < 9; i++) begin
			va = 8'($urandom);
			apb(1'b1, 8'(i % 3) << 2, {24'h00_0000, va});
			rdc(8'(i % 3) << 2, {24'h00_0000, va});
		end
		// internal rates and stop codes
		for (int c = 0; c < 5; c++) begin
			for (int x = 0; x < 2; x++) begin
				apb(1'b1, EVT_OFF_CTRL1, 32'(x));
				apb(1'b1, EVT_OFF_CTRL0, 32'(c));
				apb(1'b1, EVT_OFF_COUNT, 32'h0000_0000);
				repeat (span_of(c, x)) @(posedge clk);
				apb(1'b0, EVT_OFF_COUNT, 32'h0000_0000);
				check(near(rd, (c % 4 == 0) ? 0 : 16, (c % 4 == 0) ? 0 : 1), 1);
			end
		end
		// external clock edges
		for (int c = 5; c < 8; c++) begin
			apb(1'b1, EVT_OFF_CTRL0, 32'(c));
			apb(1'b1, EVT_OFF_COUNT, 32'h0000_0000);
			pulses <= 8'(3 + $urandom % 20);
			half <= 4'(2 + $urandom % 4);
			src_start <= 1'b1;
			@(posedge clk);
			src_start <= 1'b0;
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (src_busy && n < 1000);
			repeat (6) @(posedge clk);
			rdc(EVT_OFF_COUNT, 32'(pulses) * ((c == 7) ? 2 : 1));
		end
		// matches steer output, clear on b, flags and interrupts
		apb(1'b1, EVT_OFF_CTRL0, 32'h0000_0000);
		apb(1'b1, EVT_OFF_CTRL1, 32'h0000_0000);
		va = 8'(8 + $urandom % 32);
		vb = va + 8'(4 + $urandom % 32);
		apb(1'b1, EVT_OFF_CMPA, 32'(va));
		apb(1'b1, EVT_OFF_CMPB, 32'(vb));
		apb(1'b0, EVT_OFF_STAT, 32'h0000_0000);
		apb(1'b1, EVT_OFF_STAT, 32'h0000_0006);
		apb(1'b1, EVT_OFF_COUNT, 32'h0000_0000);
		apb(1'b1, EVT_OFF_CTRL0, 32'h0000_00f1);
		wait_wave(1'b1);
		apb(1'b0, EVT_OFF_COUNT, 32'h0000_0000);
		check(near(rd, va, 2), 1);
		check(32'(irq_a), 1);
		wait_wave(1'b0);
		apb(1'b0, EVT_OFF_COUNT, 32'h0000_0000);
		check(near(rd, 0, 2), 1);
		check(32'({irq_b, irq_a, irq_o}), 6);
		apb(1'b1, EVT_OFF_CTRL0, 32'h0000_00f0);
		apb(1'b0, EVT_OFF_STAT, 32'h0000_0000);
		check(rd & 32'h0000_00e0, 32'h0000_00c0);
		apb(1'b1, EVT_OFF_STAT, 32'h0000_0006);
		rdc(EVT_OFF_STAT, 32'h0000_0016);
		apb(1'b1, EVT_OFF_STAT, 32'h0000_00f6);
		rdc(EVT_OFF_STAT, 32'h0000_0016);
		check(32'({irq_b, irq_a}), 0);
		apb(1'b1, EVT_OFF_STAT, 32'h0000_0003);
		apb(1'b1, EVT_OFF_CTRL0, 32'h0000_0009);
		wait_wave(1'b1);
		wait_wave(1'b0);
		// overflow wraps to zero
		apb(1'b1, EVT_OFF_CTRL0, 32'h0000_0021);
		apb(1'b1, EVT_OFF_COUNT, 32'h0000_00f8);
		repeat (48) @(posedge clk);
		check(32'(irq_o), 1);
		apb(1'b0, EVT_OFF_COUNT, 32'h0000_0000);
		check(near(rd, 0, 7), 1);
		// clear pin acts only with select 11
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, EVT_OFF_CTRL0, 32'(s << 3));
			apb(1'b1, EVT_OFF_COUNT, 32'h0000_0055);
			clr_lvl <= 1'b1;
			repeat (6) @(posedge clk);
			rdc(EVT_OFF_COUNT, (s == 3) ? 32'h0000_0000 : 32'h0000_0055);
			clr_lvl <= 1'b0;
			repeat (4) @(posedge clk);
		end
		// trigger start for every edge code
		apb(1'b1, EVT_OFF_CTRL0, 32'h0000_0001);
		for (int e = 0; e < 4; e++) begin
			apb(1'b1, EVT_OFF_CTRL1, 32'h0000_0000);
			trig_lvl <= (e == 2);
			repeat (6) @(posedge clk);
			apb(1'b1, EVT_OFF_CTRL1, 32'((e << 3) | 4));
			apb(1'b1, EVT_OFF_COUNT, 32'h0000_0000);
			repeat (40) @(posedge clk);
			rdc(EVT_OFF_COUNT, 32'h0000_0000);
			trig_lvl <= (e != 2);
			repeat (60) @(posedge clk);
			apb(1'b0, EVT_OFF_COUNT, 32'h0000_0000);
			check(32'(rd != 0), 32'(e != 0));
		end
		// with trigger enable on, a match or pin clear halts until the next trigger
		for (int s = 1; s < 4; s += 2) begin
			apb(1'b1, EVT_OFF_CTRL0, 32'((s << 3) | 1));
			apb(1'b1, EVT_OFF_COUNT, 32'h0000_0000);
			clr_lvl <= (s == 3);
			repeat (200) @(posedge clk);
			clr_lvl <= 1'b0;
			rdc(EVT_OFF_COUNT, 32'h0000_0000);
			trig_lvl <= ~trig_lvl;
			repeat (20) @(posedge clk);
			apb(1'b0, EVT_OFF_COUNT, 32'h0000_0000);
			check(32'(rd != 0), 1);
		end
		finish_test();
	end
endmodule
